// file: logic/switch_global_control_regs.sv
`timescale 1ns/1ps
`include "switch_global_defs.svh"

// Operation
// R1 - Flow-control bit set enables full-duplex flow control on switch MII.
// R2 - Flow-control bit loads from its strap pin at reset; low disables.
// R3 - Speed bit selects switch MII speed: 1 is 10Mbps, 0 is 100Mbps.
// R4 - Speed bit loads from speed strap at reset; low gives 100Mbps.
// R5 - Null-VID bit replaces a null VLAN ID with the port VID; resets 0.
// R6 - Eleven-bit storm threshold joins high three bits and low byte register.
// R7 - Storm period is 50ms at 100Mb/s and 500ms at 10Mb/s.
// R8 - Threshold resets to high bits 000 and low byte 0x4A.
// R9 - LED mode bit maps three port LEDs; reset value from strap pin.
// R10 - Reserved bits read zero; factory-test registers do not alter behaviour.
module switch_global_control_regs #(
  parameter int unsigned PERIOD_FAST_CYCLES = `STORM_PERIOD_FAST_MS * `CLOCK_KHZ,
  parameter int unsigned PERIOD_SLOW_CYCLES = `STORM_PERIOD_SLOW_MS * `CLOCK_KHZ
) (
  input wire logic clock,
  input wire logic reset_n,
  input switch_global_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic flow_ctrl_strap_pin,
  input wire logic speed_strap_pin,
  input wire logic led_select_strap_pin,
  output logic mii_flow_ctrl_en,
  output logic mii_speed_10,
  output logic special_tpid_mode,
  input wire logic [11:0] vid_in,
  input wire logic [11:0] port_vid,
  output logic [11:0] vid_out,
  input wire logic [4:0] storm_enable,
  input wire logic [4:0] port_speed_10,
  input wire logic [4:0] block_seen,
  output logic [4:0] storm_limit_hit,
  output logic [10:0] storm_threshold,
  input switch_global_pkg::port_status_t [4:0] port_status,
  output logic [4:0] port_led_two,
  output logic [4:0] port_led_one,
  output logic [4:0] port_led_zero
);

  localparam logic [22:0] FAST_LIM = 23'(PERIOD_FAST_CYCLES - 1);
  localparam logic [22:0] SLOW_LIM = 23'(PERIOD_SLOW_CYCLES - 1);

  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Strap synchronisers
  logic [2:0] strap_s1_q, strap_s2_q, strap_s3_q;
  switch_global_pkg::strap_phase_t phase_q, phase_d;
  logic [1:0] settle_q, settle_d;

  // Registers
  logic flow_q, flow_d;
  logic speed10_q, speed10_d;
  logic nullvid_q, nullvid_d;
  logic [2:0] storm_hi_q, storm_hi_d;
  logic [7:0] storm_lo_q, storm_lo_d;
  logic [7:0] fta_q, fta_d, ftb_q, ftb_d, ftc_q, ftc_d;
  logic led_mode_q, led_mode_d;
  logic tpid_q, tpid_d;
  logic [7:0] rdata_q, rdata_d;
  logic [11:0] vid_q, vid_d;
  logic wr_ok;

  assign wr_ok = reg_req.wr && (phase_q == switch_global_pkg::STRAP_DONE);

  always_comb begin
    phase_d = phase_q;
    settle_d = settle_q;
    flow_d = flow_q;
    speed10_d = speed10_q;
    nullvid_d = nullvid_q;
    storm_hi_d = storm_hi_q;
    storm_lo_d = storm_lo_q;
    fta_d = fta_q;
    ftb_d = ftb_q;
    ftc_d = ftc_q;
    led_mode_d = led_mode_q;
    tpid_d = tpid_q;
    unique case (phase_q)
      switch_global_pkg::STRAP_SETTLE: begin
        if (settle_q == `STRAP_SETTLE_CYCLES && strap_s2_q == strap_s3_q) begin
          phase_d = switch_global_pkg::STRAP_DONE;
          flow_d = strap_s3_q[2]; // [R2]
          speed10_d = strap_s3_q[1]; // [R4]
          led_mode_d = strap_s3_q[0]; // [R9]
        end else if (settle_q != `STRAP_SETTLE_CYCLES) begin
          settle_d = settle_q + 2'h1;
        end
      end
      switch_global_pkg::STRAP_DONE: begin
        if (wr_ok) begin
          unique case (reg_req.addr)
            `OFS_MII_STORM_HIGH: begin
              flow_d = reg_req.wdata[`BIT_FLOW_CTRL];
              speed10_d = reg_req.wdata[`BIT_SPEED_10];
              nullvid_d = reg_req.wdata[`BIT_NULL_VID];
              storm_hi_d = reg_req.wdata[2:0]; // [R6]
            end
            `OFS_STORM_LOW: storm_lo_d = reg_req.wdata; // [R6]
            `OFS_FACTORY_A: fta_d = reg_req.wdata;
            `OFS_FACTORY_B: ftb_d = reg_req.wdata;
            `OFS_FACTORY_C: ftc_d = reg_req.wdata;
            `OFS_LED_TPID: begin
              led_mode_d = reg_req.wdata[`BIT_LED_MODE];
              tpid_d = reg_req.wdata[`BIT_SPECIAL_TPID];
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  // Read path and VID replacement
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `OFS_MII_STORM_HIGH: rdata_d = {2'h0, flow_q, speed10_q, nullvid_q, storm_hi_q};
        `OFS_STORM_LOW: rdata_d = storm_lo_q;
        `OFS_FACTORY_A: rdata_d = fta_q;
        `OFS_FACTORY_B: rdata_d = ftb_q;
        `OFS_FACTORY_C: rdata_d = ftc_q;
        `OFS_LED_TPID: rdata_d = {6'h00, led_mode_q, tpid_q}; // [R10]
        default: rdata_d = 8'h00;
      endcase
    end
    vid_d = (nullvid_q && vid_in == 12'h000) ? port_vid : vid_in; // [R5]
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      strap_s3_q <= 3'h0;
      phase_q <= switch_global_pkg::STRAP_SETTLE;
      settle_q <= 2'h0;
      flow_q <= 1'b0;
      speed10_q <= 1'b0;
      nullvid_q <= `RST_NULL_VID; // [R5]
      storm_hi_q <= `RST_STORM_HIGH; // [R8]
      storm_lo_q <= `RST_STORM_LOW; // [R8]
      fta_q <= `RST_FACTORY_A;
      ftb_q <= `RST_FACTORY_B;
      ftc_q <= `RST_FACTORY_C;
      led_mode_q <= 1'b0;
      tpid_q <= `RST_SPECIAL_TPID;
      rdata_q <= 8'h00;
      vid_q <= 12'h000;
    end else begin
      strap_s1_q <= {flow_ctrl_strap_pin, speed_strap_pin, led_select_strap_pin};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      phase_q <= phase_d;
      settle_q <= settle_d;
      flow_q <= flow_d;
      speed10_q <= speed10_d;
      nullvid_q <= nullvid_d;
      storm_hi_q <= storm_hi_d;
      storm_lo_q <= storm_lo_d;
      fta_q <= fta_d;
      ftb_q <= ftb_d;
      ftc_q <= ftc_d;
      led_mode_q <= led_mode_d;
      tpid_q <= tpid_d;
      rdata_q <= rdata_d;
      vid_q <= vid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign mii_flow_ctrl_en = flow_q; // [R1]
  assign mii_speed_10 = speed10_q; // [R3]
  assign special_tpid_mode = tpid_q;
  assign vid_out = vid_q;
  assign storm_threshold = {storm_hi_q, storm_lo_q}; // [R6]

  // Per-port storm period and block counting
  logic [22:0] per_cnt_q [5];
  logic [22:0] per_cnt_d [5];
  logic [11:0] blk_cnt_q [5];
  logic [11:0] blk_cnt_d [5];

  always_comb begin
    for (int p = 0; p < 5; p++) begin
      per_cnt_d[p] = per_cnt_q[p] + 23'h1;
      blk_cnt_d[p] = blk_cnt_q[p];
      if (per_cnt_q[p] >= (port_speed_10[p] ? SLOW_LIM : FAST_LIM)) begin // [R7]
        per_cnt_d[p] = 23'h0;
        blk_cnt_d[p] = 12'h000;
      end else if (block_seen[p] && blk_cnt_q[p] != 12'hFFF) begin
        blk_cnt_d[p] = blk_cnt_q[p] + 12'h1;
      end
      storm_limit_hit[p] = storm_enable[p] && (blk_cnt_q[p] >= {1'b0, storm_threshold});
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int p = 0; p < 5; p++) begin
        per_cnt_q[p] <= 23'h0;
        blk_cnt_q[p] <= 12'h000;
      end
    end else begin
      for (int p = 0; p < 5; p++) begin
        per_cnt_q[p] <= per_cnt_d[p];
        blk_cnt_q[p] <= blk_cnt_d[p];
      end
    end
  end

  // LED mapping
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      if (led_mode_q) begin // [R9]
        port_led_two[p] = port_status[p].link_act && port_status[p].speed_100;
        port_led_one[p] = port_status[p].link_act && !port_status[p].speed_100;
        port_led_zero[p] = port_status[p].full_duplex;
      end else begin
        port_led_two[p] = port_status[p].link_act;
        port_led_one[p] = port_status[p].full_duplex || port_status[p].collision;
        port_led_zero[p] = port_status[p].speed_100;
      end
    end
  end

  // Checks
  property p_flow_write;
    @(posedge clock) disable iff (!rst_n_q)
    wr_ok && reg_req.addr == `OFS_MII_STORM_HIGH
      |=> mii_flow_ctrl_en == $past(reg_req.wdata[`BIT_FLOW_CTRL]);
  endproperty
  a_flow_write: assert property (p_flow_write) else $error("flow bit not written"); // [R1]

  property p_flow_strap;
    @(posedge clock) disable iff (!rst_n_q)
    $rose(phase_q) |-> mii_flow_ctrl_en == $past(strap_s3_q[2]);
  endproperty
  a_flow_strap: assert property (p_flow_strap) else $error("flow strap not loaded"); // [R2]

  property p_speed_write;
    @(posedge clock) disable iff (!rst_n_q)
    wr_ok && reg_req.addr == `OFS_MII_STORM_HIGH
      |=> mii_speed_10 == $past(reg_req.wdata[`BIT_SPEED_10]);
  endproperty
  a_speed_write: assert property (p_speed_write) else $error("speed bit not written"); // [R3]

  property p_speed_strap;
    @(posedge clock) disable iff (!rst_n_q)
    $rose(phase_q) |-> mii_speed_10 == $past(strap_s3_q[1]);
  endproperty
  a_speed_strap: assert property (p_speed_strap) else $error("speed strap not loaded"); // [R4]

  property p_null_vid;
    @(posedge clock) disable iff (!rst_n_q)
    nullvid_q && vid_in == 12'h000 |=> vid_out == $past(port_vid);
  endproperty
  a_null_vid: assert property (p_null_vid) else $error("null VID not replaced"); // [R5]

  property p_storm_low;
    @(posedge clock) disable iff (!rst_n_q)
    wr_ok && reg_req.addr == `OFS_STORM_LOW |=> storm_threshold[7:0] == $past(reg_req.wdata);
  endproperty
  a_storm_low: assert property (p_storm_low) else $error("threshold low byte wrong"); // [R6]

  property p_period;
    @(posedge clock) disable iff (!rst_n_q)
    per_cnt_q[0] == FAST_LIM && !port_speed_10[0]
      |=> per_cnt_q[0] == 23'h0 && blk_cnt_q[0] == 12'h000;
  endproperty
  a_period: assert property (p_period) else $error("storm period not restarted"); // [R7]

  property p_storm_reset;
    @(posedge clock) disable iff (!rst_n_q)
    phase_q == switch_global_pkg::STRAP_SETTLE |-> storm_threshold == 11'h04A;
  endproperty
  a_storm_reset: assert property (p_storm_reset) else $error("threshold reset wrong"); // [R8]

  property p_led_mode1;
    @(posedge clock) disable iff (!rst_n_q)
    led_mode_q |-> port_led_one[0] == (port_status[0].link_act && !port_status[0].speed_100);
  endproperty
  a_led_mode1: assert property (p_led_mode1) else $error("led mode 1 mapping wrong"); // [R9]

  property p_reserved;
    @(posedge clock) disable iff (!rst_n_q)
    reg_req.rd && reg_req.addr == `OFS_LED_TPID |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R10]

  c_strap_done: cover property (@(posedge clock) disable iff (!rst_n_q) $rose(phase_q));
  c_storm_hit: cover property (@(posedge clock) disable iff (!rst_n_q) storm_limit_hit[0]);
  c_vid_swap: cover property (@(posedge clock) disable iff (!rst_n_q)
    nullvid_q && vid_in == 12'h000);

endmodule : switch_global_control_regs

// file: logic/switch_global_defs.svh
`ifndef SWITCH_GLOBAL_DEFS_SVH
`define SWITCH_GLOBAL_DEFS_SVH

// Register offsets
`define OFS_MII_STORM_HIGH 8'h06
`define OFS_STORM_LOW 8'h07
`define OFS_FACTORY_A 8'h08
`define OFS_FACTORY_B 8'h09
`define OFS_FACTORY_C 8'h0A
`define OFS_LED_TPID 8'h0B

// Field positions
`define BIT_FLOW_CTRL 5
`define BIT_SPEED_10 4
`define BIT_NULL_VID 3
`define BIT_LED_MODE 1
`define BIT_SPECIAL_TPID 0

// Reset values
`define RST_STORM_HIGH 3'h0
`define RST_STORM_LOW 8'h4A
`define RST_FACTORY_A 8'h24
`define RST_FACTORY_B 8'h28
`define RST_FACTORY_C 8'h24
`define RST_NULL_VID 1'h0
`define RST_SPECIAL_TPID 1'h0

// Timing
`define CLOCK_KHZ 10000
`define STORM_PERIOD_FAST_MS 50
`define STORM_PERIOD_SLOW_MS 500
`define STRAP_SETTLE_CYCLES 2'h3

`endif

// file: logic/switch_global_pkg.sv
package switch_global_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic link_act;
    logic speed_100;
    logic full_duplex;
    logic collision;
  } port_status_t;

  typedef enum logic [0:0] {
    STRAP_SETTLE = 1'b0,
    STRAP_DONE = 1'b1
  } strap_phase_t;

endpackage : switch_global_pkg

// file: verif/switch_global_control_regs_test.sv
`timescale 1ns/1ps
module switch_global_control_regs_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  switch_global_pkg::reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic [2:0] straps = 3'h0;
  logic mii_flow_ctrl_en, mii_speed_10, special_tpid_mode;
  logic [11:0] vid_in = 12'h000, port_vid = 12'h000;
  logic [11:0] vid_out;
  logic [4:0] storm_enable = 5'h00, port_speed_10 = 5'h00, block_seen = 5'h00;
  logic [4:0] storm_limit_hit, port_led_two, port_led_one, port_led_zero;
  logic [10:0] storm_threshold;
  switch_global_pkg::port_status_t [4:0] port_status = '0;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] regs [0:255];

  always #50 clock = ~clock;

  switch_global_control_regs #(.PERIOD_FAST_CYCLES(20), .PERIOD_SLOW_CYCLES(200)) u_dut (
    .clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .flow_ctrl_strap_pin(straps[2]), .speed_strap_pin(straps[1]),
    .led_select_strap_pin(straps[0]), .mii_flow_ctrl_en(mii_flow_ctrl_en),
    .mii_speed_10(mii_speed_10), .special_tpid_mode(special_tpid_mode),
    .vid_in(vid_in), .port_vid(port_vid), .vid_out(vid_out),
    .storm_enable(storm_enable), .port_speed_10(port_speed_10), .block_seen(block_seen),
    .storm_limit_hit(storm_limit_hit), .storm_threshold(storm_threshold),
    .port_status(port_status), .port_led_two(port_led_two),
    .port_led_one(port_led_one), .port_led_zero(port_led_zero)
  );

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : step

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h06: return 8'h3F;
      8'h07, 8'h08, 8'h09, 8'h0A: return 8'hFF;
      8'h0B: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : mask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = {1'b1, 1'b0, a, d};
    step(1);
    reg_req = '0;
    regs[a] = d & mask(a);
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_req = {1'b0, 1'b1, a, 8'h00};
    step(1);
    reg_req = '0;
    step(1);
    chk(reg_rdata, regs[a], "read data");
  endtask : rd

  task automatic outs;
    chk(mii_flow_ctrl_en, regs[6][5], "flow control");
    chk(mii_speed_10, regs[6][4], "mii speed");
    chk(storm_threshold, {regs[6][2:0], regs[7]}, "threshold");
    chk(special_tpid_mode, regs[11][0], "tpid mode");
  endtask : outs

  task automatic leds;
    logic m;
    switch_global_pkg::port_status_t s;
    m = regs[11][1];
    for (int p = 0; p < 5; p++) begin
      s = port_status[p];
      chk({port_led_two[p], port_led_one[p], port_led_zero[p]}, m ?
        {s.link_act & s.speed_100, s.link_act & ~s.speed_100, s.full_duplex} :
        {s.link_act, s.full_duplex | s.collision, s.speed_100}, "leds");
    end
  endtask : leds

  task automatic do_reset(input logic [2:0] s);
    straps = s;
    reset_n = 1'b0;
    step(12);
    reset_n = 1'b1;
    step(10);
    regs = '{default: 8'h00};
    regs[6] = {2'b00, s[2], s[1], 4'h0};
    regs[7] = 8'h4A;
    regs[8] = 8'h24;
    regs[9] = 8'h28;
    regs[10] = 8'h24;
    regs[11] = {6'h00, s[0], 1'b0};
  endtask : do_reset

  task automatic vid(input logic [11:0] v, input logic [11:0] pv);
    vid_in = v;
    port_vid = pv;
    step(1);
    chk(vid_out, (regs[6][3] && v == 12'h000) ? pv : v, "vid");
  endtask : vid

  initial begin
    logic [2:0] s0;
    logic [7:0] a;
    int n;
    void'($urandom(32'h967A));
    s0 = $urandom;
    step(1);
    for (int i = 0; i < 2; i++) begin
      do_reset(i ? ~s0 : s0);
      outs();
      for (int r = 6; r < 12; r++) rd(r);
      leds();
      $display("reset test %0d done", i);
    end
    repeat (40) begin
      a = 8'h05 + ($urandom % 8);
      port_status = $urandom;
      wr(a, $urandom);
      rd(a);
      outs();
      leds();
    end
    $display("register test done");
    wr(6, regs[6] | 8'h08);
    vid(12'h000, $urandom);
    vid(12'h001 | $urandom, $urandom);
    wr(6, regs[6] & 8'hF7);
    vid(12'h000, 12'h001 | $urandom);
    $display("vid test done");
    wr(6, regs[6] & 8'hF8);
    wr(7, 8'h02);
    storm_enable = 5'h03;
    port_speed_10 = 5'h02;
    block_seen = 5'h07;
    n = 0;
    while (storm_limit_hit[0] !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    chk(n < 6, 1'b1, "storm hit late");
    chk(storm_limit_hit[2], 1'b0, "storm gating");
    for (int p = 0; p < 2; p++) begin
      n = 0;
      while (storm_limit_hit[p] !== 1'b1 && n < 5) begin
        step(1);
        n++;
      end
      while (storm_limit_hit[p] !== 1'b0 && n < 220) begin
        step(1);
        n++;
      end
      n = 0;
      while (storm_limit_hit[p] !== 1'b1 && n < 5) begin
        step(1);
        n++;
      end
      while (storm_limit_hit[p] !== 1'b0 && n < 220) begin
        step(1);
        n++;
      end
      chk(n, p ? 200 : 20, "storm period length");
    end
    block_seen = 5'h00;
    n = 0;
    while (storm_limit_hit[0] !== 1'b0 && n < 30) begin
      step(1);
      n++;
    end
    chk(n < 22, 1'b1, "storm period");
    $display("storm test done");
    results();
  end

  initial begin
    #200000;
    failures++;
    results();
  end
endmodule : switch_global_control_regs_test
